// ---- stpin_host.sv ----
// host serial master model driving the chip-select port
`timescale 1ns/1ns
module stpin_host (
    input  wire logic ref_clk,
    input  wire logic sdo_oe_n,
    output logic      sclk,
    output logic      cs_n,
    output logic      sdi
);
    logic [7:0] got;
    // idle pins: clock high, deselected
    initial
    begin
        sclk = 1'h1;
        cs_n = 1'h1;
        sdi  = 1'h1;
    end
    // one byte msb first: data set on fall, read on rise
    task automatic xfer(input logic [7:0] b);
        cs_n <= 1'h0;
        repeat (6) @(posedge ref_clk);
        for (int i = 7; i >= 0; i--)
        begin
            sclk <= 1'h0;
            sdi  <= b[i];
            repeat (6) @(posedge ref_clk);
            sclk <= 1'h1;
            got[i] = sdo_oe_n;
            repeat (6) @(posedge ref_clk);
        end
        cs_n <= 1'h1;
        sdi  <= ~sdi; // released line no longer holds data
    endtask
endmodule

// ---- stpin_pkg.sv ----
// shared constants for the s/t pin mode and clock logic
package stpin_pkg;
    // operating modes decoded from the mode straps, all but STPIN_NETWORK
    typedef enum logic [1:0] {
        STPIN_ENDPOINT,
        STPIN_TRUNK,
        STPIN_SUBSCRIBER,
        STPIN_NETWORK
    } stpin_mode_type;

    // reference clock rate in hz
    localparam int unsigned REF_HZ           = 10000000;
    // frame marker rate in hz and derived cycle count
    localparam int unsigned FRAME_HZ         = 8000;
    localparam int unsigned FRAME_CYCLES     = REF_HZ / FRAME_HZ;
    // wake pulse length in ns and derived cycle count (rounded up)
    localparam int unsigned WAKE_PULSE_NS    = 1000;
    localparam int unsigned WAKE_PULSE_CYC   = (WAKE_PULSE_NS * (REF_HZ / 1000000) + 999) / 1000;
    // host serial port group width
    localparam int unsigned SER_BITS         = 8;
    // reset values
    localparam logic [2:0]  GPIO_DIR_RESET   = 3'h0;
    localparam logic [2:0]  GPIO_OUT_RESET   = 3'h0;
    localparam logic        IRQ_HIGH_RESET   = 1'h0;
    localparam logic        WAKE_RST_RESET   = 1'h0;
endpackage

// ---- stpin_serial.sv ----
// host serial port: byte shifter, sample on rising, drive on falling serial clock
`timescale 1ns/1ns
module stpin_serial (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       sclk_s,
    input  wire logic       cs_n_s,
    input  wire logic       serial_in_s,
    input  wire logic       port_enable,
    input  wire logic [7:0] tx_byte,
    output logic            serial_out_line,
    output logic            serial_out_oe_n,
    output logic      [7:0] rx_byte,
    output logic            rx_valid,
    output logic            access_active
);
    logic       sclk_d_reg;
    logic       sclk_d_next;
    logic       cs_d_reg;
    logic       cs_d_next;
    logic [7:0] shift_in_reg;
    logic [7:0] shift_in_next;
    logic [7:0] shift_out_reg;
    logic [7:0] shift_out_next;
    logic [2:0] count_reg;
    logic [2:0] count_next;
    logic [7:0] rx_byte_reg;
    logic [7:0] rx_byte_next;
    logic       rx_valid_reg;
    logic       rx_valid_next;
    logic       drive_reg;
    logic       drive_next;
    logic       rise;
    logic       fall;
    logic       sel;

    assign sel  = port_enable && !cs_n_s;
    assign rise = sclk_s && !sclk_d_reg;
    assign fall = !sclk_s && sclk_d_reg;

    // shifter next state
    always_comb
    begin
        sclk_d_next    = sclk_s;
        cs_d_next      = cs_n_s;
        shift_in_next  = shift_in_reg;
        shift_out_next = shift_out_reg;
        count_next     = count_reg;
        rx_byte_next   = rx_byte_reg;
        rx_valid_next  = 1'b0;
        drive_next     = drive_reg;
        if (!sel)
        begin
            count_next = 3'h0; // access closes on chip select rise
            drive_next = 1'b0;
        end
        if (sel && cs_d_reg)
        begin
            count_next     = 3'h0; // chip select fall opens access
            shift_out_next = tx_byte;
            drive_next     = 1'b0;
        end
        else if (sel && rise)
        begin
            shift_in_next = {shift_in_reg[6:0], serial_in_s}; // msb first
            count_next    = count_reg + 3'h1;
            if (count_reg == 3'h7)
            begin
                rx_byte_next  = {shift_in_reg[6:0], serial_in_s}; // 8-bit group
                rx_valid_next = 1'b1;
            end
        end
        else if (sel && fall)
        begin
            drive_next     = 1'b1; // output changes on falling edge
            shift_out_next = (count_reg == 3'h0) ? tx_byte : {shift_out_reg[6:0], 1'b1};
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            sclk_d_reg    <= 1'b1; // idle level of the serial clock
            cs_d_reg      <= 1'b1;
            shift_in_reg  <= 8'h00;
            shift_out_reg <= 8'hff;
            count_reg     <= 3'h0;
            rx_byte_reg   <= 8'h00;
            rx_valid_reg  <= 1'b0;
            drive_reg     <= 1'b0;
        end
        else
        begin
            sclk_d_reg    <= sclk_d_next;
            cs_d_reg      <= cs_d_next;
            shift_in_reg  <= shift_in_next;
            shift_out_reg <= shift_out_next;
            count_reg     <= count_next;
            rx_byte_reg   <= rx_byte_next;
            rx_valid_reg  <= rx_valid_next;
            drive_reg     <= drive_next;
        end
    end

    // open drain: enable low only while pulling low
    assign serial_out_line = 1'b0;
    assign serial_out_oe_n = !(drive_reg && sel && !shift_out_reg[7]);
    assign rx_byte         = rx_byte_reg;
    assign rx_valid        = rx_valid_reg;
    assign access_active   = sel;

    // a byte is only complete inside an access
    rx_in_access_a: assert property (@(posedge ref_clk) disable iff (rst)
        rx_valid |-> $past(sel))
        else $error("byte completed outside an access");
endmodule

// ---- stpin_sync.sv ----
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ns
module stpin_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    initial
    begin
        if (WIDTH < 1)
        begin
            $error("stpin_sync: width must be at least one");
        end
    end

    // first stage feeds only the second stage
    always_comb
    begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    // registers, cleared by synchronous reset
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule

// ---- stpin_top.sv ----
// pin-level mode, clock, strobe and host-port logic of the s/t transceiver
`timescale 1ns/1ns
module stpin_top #(
    parameter int unsigned SLOT_BITS = 5
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic                 hard_clear_in_n,
    input  wire logic                 first_mode_pin,
    input  wire logic                 second_mode_pin,
    input  wire logic                 xtal_clock_in,
    input  wire logic                 line_clock_in,
    input  wire logic                 line_d_bit,
    input  wire logic                 sclk_pin,
    input  wire logic                 cs_n_pin,
    input  wire logic                 serial_in_line,
    output logic                      serial_out_line,
    output logic                      serial_out_oe_n,
    input  wire logic [7:0]           serial_tx_byte,
    output logic      [7:0]           serial_rx_byte,
    output logic                      serial_rx_valid,
    output logic                      host_access,
    output logic                      monitor_slave_sel,
    input  wire logic                 frame_sync_in,
    output logic                      frame_sync_out,
    output logic                      frame_sync_oe_n,
    input  wire logic                 double_rate_clock_in,
    output logic                      double_rate_clock_out,
    output logic                      double_rate_clock_oe_n,
    output logic                      bit_rate_clock,
    input  wire logic [2:0]           general_io_pins_in,
    output logic      [2:0]           general_io_pins_out,
    output logic      [2:0]           general_io_pins_oe_n,
    input  wire logic [2:0]           gpio_dir_out,
    input  wire logic [2:0]           gpio_out_value,
    output logic      [2:0]           gpio_in_value,
    output logic      [2:0]           slot_select,
    input  wire logic                 irq_request,
    input  wire logic                 irq_active_high,
    output logic                      irq_out,
    output logic                      irq_oe_n,
    input  wire logic                 wake_reset_enable,
    output logic                      wake_event,
    input  wire logic                 watchdog_expired,
    input  wire logic                 host_reset_cmd,
    output logic                      reset_out_pin,
    output logic                      reset_out_oe_n,
    output logic                      crystal_clock_out,
    output logic                      d_activity_out,
    input  wire logic [SLOT_BITS-1:0] strobe_one_slot,
    input  wire logic [1:0]           strobe_one_sel,
    input  wire logic [SLOT_BITS-1:0] strobe_two_slot,
    input  wire logic [1:0]           strobe_two_sel,
    input  wire logic                 d_channel_pos,
    output logic                      strobe_one,
    output logic                      strobe_two,
    output stpin_pkg::stpin_mode_type mode
);
    initial
    begin
        if (SLOT_BITS < 1 || SLOT_BITS > 8)
        begin
            $error("stpin_top: slot width out of range");
        end
    end

    // synchronised pin inputs
    logic [9:0] pin_s;
    stpin_sync #(.WIDTH(10)) u_sync (
        .ref_clk  (ref_clk),
        .rst      (1'b0),
        .async_in ({hard_clear_in_n, first_mode_pin, second_mode_pin, double_rate_clock_in,
                    line_clock_in, line_d_bit, frame_sync_in, general_io_pins_in}),
        .sync_out (pin_s)
    );
    logic       clear_s;
    logic       first_mode_pin_s;
    logic       second_mode_pin_s;
    logic       dcl_s;
    logic       line_clk_s;
    logic       dbit_s;
    logic       fsc_s;
    logic [2:0] aux_s;
    assign clear_s    = pin_s[9];
    assign first_mode_pin_s    = pin_s[8];
    assign second_mode_pin_s    = pin_s[7];
    assign dcl_s      = pin_s[6];
    assign line_clk_s = pin_s[5];
    assign dbit_s     = pin_s[4];
    assign fsc_s      = pin_s[3];
    assign aux_s      = pin_s[2:0];

    // whole device reset: logic reset or hard clear held low
    logic dev_rst;
    assign dev_rst = rst || !clear_s;

    // serial clock and control sync, kept running in reset so the strap is seen
    logic [2:0] ser_s;
    stpin_sync #(.WIDTH(3)) u_ser_sync (
        .ref_clk  (ref_clk),
        .rst      (1'b0),
        .async_in ({sclk_pin, cs_n_pin, serial_in_line}),
        .sync_out (ser_s)
    );

    // state registers
    stpin_pkg::stpin_mode_type mode_reg;
    stpin_pkg::stpin_mode_type mode_next;
    logic                      mon_reg;
    logic                      mon_next;
    logic                      wake_d_reg;
    logic                      wake_d_next;
    logic                      wake_ev_reg;
    logic                      wake_ev_next;
    logic [7:0]                wake_cnt_reg;
    logic [7:0]                wake_cnt_next;
    logic                      bclk_reg;
    logic                      bclk_next;
    logic                      dcl_d_reg;
    logic                      dcl_d_next;
    logic [10:0]               frame_cnt_reg;
    logic [10:0]               frame_cnt_next;
    logic                      dclk_out_reg;
    logic                      dclk_out_next;
    logic                      fsc_out_reg;
    logic                      fsc_out_next;
    logic [SLOT_BITS-1:0]      slot_reg;
    logic [SLOT_BITS-1:0]      slot_next;
    logic                      fsc_d_reg;
    logic                      fsc_d_next;
    logic [1:0]                strobe_reg;
    logic [1:0]                strobe_next;
    logic                      dca_reg;
    logic                      dca_next;
    logic [2:0]                gpio_in_reg;
    logic [2:0]                gpio_in_next;
    logic [2:0]                slot_sel_reg;
    logic [2:0]                slot_sel_next;

    // strobe decode, used for both strobes
    function automatic logic strobe_hit(input logic [SLOT_BITS-1:0] slot,
                                        input logic [SLOT_BITS-1:0] want,
                                        input logic [1:0]           sel,
                                        input logic                 dpos);
        strobe_hit = (sel[0] && slot == want) || (sel[1] && dpos);
    endfunction

    logic device_times;
    assign device_times = (mode_reg == stpin_pkg::STPIN_NETWORK) ? 1'b0 : 1'b1;

    // mode, wake, clocks, frame and strobes next state
    always_comb
    begin
        mode_next      = mode_reg;
        mon_next       = mon_reg;
        wake_d_next    = second_mode_pin_s;
        wake_ev_next   = 1'b0;
        wake_cnt_next  = wake_cnt_reg;
        bclk_next      = bclk_reg;
        dcl_d_next     = dcl_s;
        frame_cnt_next = frame_cnt_reg;
        dclk_out_next  = dclk_out_reg;
        fsc_out_next   = fsc_out_reg;
        slot_next      = slot_reg;
        fsc_d_next     = fsc_s;
        dca_next       = dbit_s;
        gpio_in_next   = aux_s;
        slot_sel_next  = slot_sel_reg;
        // straps decoded every cycle; board holds them static
        if (!first_mode_pin_s)
        begin
            mode_next = stpin_pkg::STPIN_ENDPOINT;
        end
        else if (!second_mode_pin_s)
        begin
            mode_next = stpin_pkg::STPIN_TRUNK;
        end
        else
        begin
            mode_next = stpin_pkg::STPIN_SUBSCRIBER;
        end
        // falling wake edge in endpoint mode
        if (mode_reg == stpin_pkg::STPIN_ENDPOINT && wake_d_reg && !second_mode_pin_s)
        begin
            wake_ev_next = 1'b1;
            if (wake_reset_enable)
            begin
                wake_cnt_next = 8'(stpin_pkg::WAKE_PULSE_CYC);
            end
        end
        else if (wake_cnt_reg != 8'h00)
        begin
            wake_cnt_next = wake_cnt_reg - 8'h01;
        end
        // bit clock follows the line clock in trunk mode, else toggles on each rising double-rate clock edge
        if (mode_reg == stpin_pkg::STPIN_TRUNK)
        begin
            bclk_next = line_clk_s;
        end
        else if (dcl_s && !dcl_d_reg)
        begin
            bclk_next = !bclk_reg;
        end
        // own highway timing when device is the timing source
        dclk_out_next = !dclk_out_reg;
        if (frame_cnt_reg == 11'(stpin_pkg::FRAME_CYCLES - 1))
        begin
            frame_cnt_next = 11'h000;
            fsc_out_next   = 1'b1;
        end
        else
        begin
            frame_cnt_next = frame_cnt_reg + 11'h001;
            fsc_out_next   = 1'b0;
        end
        // slot counter from frame marker and bit clock
        if (fsc_s && !fsc_d_reg)
        begin
            slot_next = '0;
        end
        else if (dcl_s && !dcl_d_reg && bclk_reg)
        begin
            slot_next = slot_reg + SLOT_BITS'(1);
        end
        strobe_next[0] = strobe_hit(slot_reg, strobe_one_slot, strobe_one_sel, d_channel_pos);
        strobe_next[1] = strobe_hit(slot_reg, strobe_two_slot, strobe_two_sel, d_channel_pos);
        if (mode_reg != stpin_pkg::STPIN_ENDPOINT)
        begin
            slot_sel_next = aux_s;
        end
    end

    // host interface strap caught while reset is held
    always_ff @(posedge ref_clk)
    begin
        if (dev_rst)
        begin
            mon_reg <= !ser_s[1];
        end
        else
        begin
            mon_reg <= mon_next;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (dev_rst)
        begin
            mode_reg      <= stpin_pkg::STPIN_ENDPOINT;
            wake_d_reg    <= 1'b0; // no false wake edge with the pin low after reset
            wake_ev_reg   <= 1'b0;
            wake_cnt_reg  <= 8'h00;
            bclk_reg      <= 1'b0;
            dcl_d_reg     <= 1'b0;
            frame_cnt_reg <= 11'h000;
            dclk_out_reg  <= 1'b0;
            fsc_out_reg   <= 1'b0;
            slot_reg      <= '0;
            fsc_d_reg     <= 1'b0;
            strobe_reg    <= 2'h0;
            dca_reg       <= 1'b0;
            gpio_in_reg   <= 3'h0;
            slot_sel_reg  <= 3'h0;
        end
        else
        begin
            mode_reg      <= mode_next;
            wake_d_reg    <= wake_d_next;
            wake_ev_reg   <= wake_ev_next;
            wake_cnt_reg  <= wake_cnt_next;
            bclk_reg      <= bclk_next;
            dcl_d_reg     <= dcl_d_next;
            frame_cnt_reg <= frame_cnt_next;
            dclk_out_reg  <= dclk_out_next;
            fsc_out_reg   <= fsc_out_next;
            slot_reg      <= slot_next;
            fsc_d_reg     <= fsc_d_next;
            strobe_reg    <= strobe_next;
            dca_reg       <= dca_next;
            gpio_in_reg   <= gpio_in_next;
            slot_sel_reg  <= slot_sel_next;
        end
    end

    // host serial port, only when strapped for serial control
    stpin_serial u_serial (
        .ref_clk         (ref_clk),
        .rst             (dev_rst),
        .sclk_s          (ser_s[2]),
        .cs_n_s          (ser_s[1]),
        .serial_in_s     (ser_s[0]),
        .port_enable     (!mon_reg),
        .tx_byte         (serial_tx_byte),
        .serial_out_line (serial_out_line),
        .serial_out_oe_n (serial_out_oe_n),
        .rx_byte         (serial_rx_byte),
        .rx_valid        (serial_rx_valid),
        .access_active   (host_access)
    );

    // aux pins: open drain outputs in endpoint mode only
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_aux
            assign general_io_pins_out[g]  = 1'b0;
            assign general_io_pins_oe_n[g] = !(mode_reg == stpin_pkg::STPIN_ENDPOINT
                                               && gpio_dir_out[g] && !gpio_out_value[g]);
        end
    endgenerate
    assign gpio_in_value = gpio_in_reg;
    assign slot_select   = slot_sel_reg;

    // interrupt pin polarity and drive
    logic irq_any;
    assign irq_any  = irq_request || wake_ev_reg;
    assign irq_out  = irq_active_high && irq_any;
    assign irq_oe_n = irq_active_high ? 1'b0 : !irq_any;
    assign wake_event = wake_ev_reg;

    // reset output pulls low on any source
    assign reset_out_pin  = 1'b0;
    assign reset_out_oe_n = !(watchdog_expired || host_reset_cmd || wake_cnt_reg != 8'h00);

    // highway drivers: device times the highway except in network-side mode
    assign frame_sync_out         = fsc_out_reg;
    assign frame_sync_oe_n        = !device_times;
    assign double_rate_clock_out  = dclk_out_reg;
    assign double_rate_clock_oe_n = !device_times;
    assign bit_rate_clock         = bclk_reg;
    assign crystal_clock_out      = xtal_clock_in;
    assign d_activity_out         = dca_reg;
    assign strobe_one             = strobe_reg[0];
    assign strobe_two             = strobe_reg[1];
    assign monitor_slave_sel      = mon_reg;
    assign mode                   = mode_reg;

    // wake edge raises event one cycle later
    wake_event_a: assert property (@(posedge ref_clk) disable iff (dev_rst)
        (mode_reg == stpin_pkg::STPIN_ENDPOINT && wake_d_reg && !second_mode_pin_s) |=> wake_ev_reg)
        else $error("wake edge did not raise event");
    // strap decode
    mode_decode_a: assert property (@(posedge ref_clk) disable iff (dev_rst)
        !$past(first_mode_pin_s) |-> mode_reg == stpin_pkg::STPIN_ENDPOINT)
        else $error("endpoint strap not decoded");
    // reset output follows watchdog
    rst_out_a: assert property (@(posedge ref_clk) disable iff (dev_rst)
        watchdog_expired |-> !reset_out_oe_n)
        else $error("reset output not pulled on watchdog");
    // frame marker only at counter wrap
    frame_mark_a: assert property (@(posedge ref_clk) disable iff (dev_rst)
        fsc_out_reg |-> frame_cnt_reg == 11'h000)
        else $error("frame marker away from frame start");
    // trunk mode bit clock follows the line clock
    trunk_clock_a: assert property (@(posedge ref_clk) disable iff (dev_rst)
        mode_reg == stpin_pkg::STPIN_TRUNK |=> bclk_reg == $past(line_clk_s))
        else $error("bit clock not following line clock");
endmodule

// ---- tb_top.sv ----
// self-checking bench for the s/t pin logic
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module tb_top;
    logic ref_clk = 1'h0, rst = 1'h1, hard_clear_in_n = 1'h1;
    logic first_mode_pin = 1'h0, second_mode_pin = 1'h1, line_d_bit = 1'h0;
    logic xtal_clock_in = 1'h0, line_clock_in = 1'h0, frame_sync_in = 1'h0;
    logic double_rate_clock_in = 1'h0, d_channel_pos = 1'h0, irq_request = 1'h0;
    logic irq_active_high = 1'h0, wake_reset_enable = 1'h0;
    logic watchdog_expired = 1'h0, host_reset_cmd = 1'h0;
    logic [7:0] serial_tx_byte = 8'h00;
    logic [2:0] general_io_pins_in = 3'h0, gpio_dir_out = 3'h0, gpio_out_value = 3'h0;
    logic [4:0] strobe_one_slot = 5'h00, strobe_two_slot = 5'h00;
    logic [1:0] strobe_one_sel = 2'h0, strobe_two_sel = 2'h0;
    logic sclk_pin, cs_n_pin, serial_in_line, serial_out_line, serial_out_oe_n;
    logic serial_rx_valid, host_access, monitor_slave_sel, frame_sync_out, frame_sync_oe_n;
    logic double_rate_clock_out, double_rate_clock_oe_n, bit_rate_clock, irq_out, irq_oe_n;
    logic wake_event, reset_out_pin, reset_out_oe_n, crystal_clock_out, d_activity_out;
    logic strobe_one, strobe_two;
    logic [7:0] serial_rx_byte;
    logic [2:0] general_io_pins_out, general_io_pins_oe_n, gpio_in_value, slot_select;
    stpin_pkg::stpin_mode_type mode;
    int failures = 0, n_checks = 0, rx_seen = 0, wakes = 0, rst_lo = 0;
    int quiet = 5, fs_gap = 0, frames = 0;
    logic dpos_d = 1'h0;
    int exp_q[$];
    logic [7:0] b;

    stpin_top stpin_top_inst (.*);
    stpin_host host_inst (.ref_clk(ref_clk), .sdo_oe_n(serial_out_oe_n), .sclk(sclk_pin),
                          .cs_n(cs_n_pin), .sdi(serial_in_line));

    // reference clock
    initial forever #50 ref_clk = ~ref_clk;
    // free-running pin stimulus
    always @(posedge ref_clk)
        {xtal_clock_in, line_clock_in, frame_sync_in, double_rate_clock_in, d_channel_pos} <= 5'($urandom);
    // model of received bytes and event counts
    always @(posedge ref_clk)
    begin
        if (serial_rx_valid === 1'h1)
        begin
            rx_seen++;
            if (exp_q.size() > 0)
                `CHK(serial_rx_byte, 8'(exp_q.pop_front()));
        end
        if (wake_event === 1'h1) wakes++;
        if (reset_out_oe_n === 1'h0) rst_lo++;
        // hold off strobe and frame checks around any reset
        if (rst === 1'h1 || hard_clear_in_n !== 1'h1) quiet = 5;
        else if (quiet > 0) quiet--;
        if (quiet == 0) `CHK(strobe_two, dpos_d);
        dpos_d = d_channel_pos;
        if (quiet != 0) fs_gap = 0;
        else if (frame_sync_out === 1'h1)
        begin
            if (fs_gap > 0) `CHK(fs_gap, stpin_pkg::FRAME_CYCLES);
            frames++;
            fs_gap = 1;
        end
        else if (fs_gap > 0) fs_gap++;
    end

    task automatic finish_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic do_reset(input logic fm, input logic sm, input logic cs);
        rst <= 1'h1;
        first_mode_pin <= fm;
        second_mode_pin <= sm;
        host_inst.cs_n <= cs;
        repeat (8) @(posedge ref_clk);
        rst <= 1'h0;
        host_inst.cs_n <= 1'h1;
        repeat (6) @(posedge ref_clk);
    endtask

    // watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        finish_test();
    end

    // main sequence
    initial
    begin
        void'($urandom(32'hfd3d18e0));
        {strobe_one_slot, strobe_two_slot, strobe_one_sel} <= 12'($urandom);
        strobe_two_sel <= 2'h2; // d-channel position only
        for (int k = 2; k >= 0; k--)
        begin
            do_reset(k != 0, k != 1, 1'h1);
            `CHK(mode, stpin_pkg::stpin_mode_type'(k));
            `CHK(monitor_slave_sel, 1'h0);
            `CHK({frame_sync_oe_n, double_rate_clock_oe_n}, 2'h0);
            {general_io_pins_in, gpio_dir_out, gpio_out_value} <= 9'($urandom);
            repeat (5) @(posedge ref_clk);
            if (k == 0)
            begin
                `CHK(gpio_in_value & ~gpio_dir_out, general_io_pins_in & ~gpio_dir_out);
                `CHK(general_io_pins_oe_n, ~(gpio_dir_out & ~gpio_out_value));
            end
            else
            begin
                `CHK(slot_select, general_io_pins_in);
                `CHK(general_io_pins_oe_n, 3'h7);
            end
            if (k == 1)
            begin
                hard_clear_in_n <= 1'h0;
                repeat (6) @(posedge ref_clk);
                `CHK(mode, stpin_pkg::STPIN_ENDPOINT);
                hard_clear_in_n <= 1'h1;
                repeat (6) @(posedge ref_clk);
                `CHK(mode, stpin_pkg::STPIN_TRUNK);
            end
        end
        @(negedge ref_clk);
        `CHK(crystal_clock_out, xtal_clock_in);
        @(posedge ref_clk);
        for (int v = 0; v < 2; v++)
        begin
            line_d_bit <= 1'(v);
            irq_active_high <= 1'(v);
            irq_request <= 1'h1;
            {host_reset_cmd, watchdog_expired} <= 2'h1 << v;
            repeat (6) @(posedge ref_clk);
            `CHK(d_activity_out, 1'(v));
            `CHK(irq_oe_n, 1'h0);
            `CHK(reset_out_oe_n, 1'h0);
            `CHK(irq_out, 1'(v));
            irq_request <= 1'h0;
            {host_reset_cmd, watchdog_expired} <= 2'h0;
            repeat (6) @(posedge ref_clk);
            `CHK(irq_oe_n, 1'(v == 0));
            `CHK(irq_out, 1'h0);
            `CHK(reset_out_oe_n, 1'h1);
        end
        rst_lo = 0;
        wake_reset_enable <= 1'h1;
        second_mode_pin <= 1'h0;
        repeat (30) @(posedge ref_clk);
        `CHK(wakes, 1);
        `CHK(rst_lo, stpin_pkg::WAKE_PULSE_CYC);
        for (int n = 0; n < 4; n++)
        begin
            b = 8'($urandom);
            serial_tx_byte <= 8'($urandom);
            if (n < 3) exp_q.push_back(b);
            if (n == 3) do_reset(1'h0, 1'h0, 1'h0);
            if (n == 3) `CHK(monitor_slave_sel, 1'h1);
            @(posedge ref_clk);
            fork
                host_inst.xfer(b);
                begin
                    repeat (20) @(posedge ref_clk);
                    `CHK(host_access, 1'(n < 3));
                end
            join
            if (n < 3) `CHK(host_inst.got, serial_tx_byte);
            repeat (8) @(posedge ref_clk);
        end
        repeat (2600) @(posedge ref_clk);
        `CHK(frames >= 2, 1'h1);
        `CHK(rx_seen, 3);
        finish_test();
    end
endmodule
